/* verilog/ifd_decoder.sv */
`include "ifd_defines.svh"

module ifd_decoder (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Instruction from fetch
   input wire logic instrValid,
   input wire logic [47:0] instrWord,
   input wire logic [`IFD_ADDR_W-1:0] instrAddr,
   input wire logic problemState,
   // Register file read ports
   output logic [3:0] indexSel,
   output logic [3:0] baseSel,
   output logic [3:0] secondBaseSel,
   input wire logic [`IFD_WORD_W-1:0] indexData,
   input wire logic [`IFD_WORD_W-1:0] baseData,
   input wire logic [`IFD_WORD_W-1:0] secondBaseData,
   // Decoded instruction to execution control
   output logic decValid,
   output ifd_pkg::ifd_format_t format,
   output logic [4:0] opIndex,
   output logic [2:0] instrLen,
   output logic [`IFD_ADDR_W-1:0] nextAddr,
   output logic [3:0] firstOperandRegister,
   output logic [3:0] secondOperandRegister,
   output logic [3:0] conditionTestMask,
   output logic maskValid,
   output logic [7:0] immValue,
   output logic immValid,
   output logic groupValid,
   output logic [1:0] storageRefs,
   output logic [`IFD_ADDR_W-1:0] operandAddrA,
   output logic [`IFD_ADDR_W-1:0] operandAddrB,
   output logic [8:0] operandLenA,
   output logic [8:0] operandLenB,
   output logic [2:0] operandBytes,
   output logic illegalOp,
   output logic privTrap,
   output logic specTrap
);
   import ifd_pkg::*;

   // ****************************************
   // Stage 1: capture and classify
   // ****************************************
   logic s1Valid, next_s1Valid;
   logic [47:0] s1Word, next_s1Word;
   logic [`IFD_ADDR_W-1:0] s1Addr, next_s1Addr;
   logic s1Problem, next_s1Problem;
   ifd_format_t s1Fmt, next_s1Fmt;
   logic [4:0] s1Op, next_s1Op;
   logic [3:0] next_indexSel, next_baseSel, next_secondBaseSel;
   logic [7:0] opc;
   logic [7:0] opOff;

   always_comb begin
      opc = instrWord[`IFD_OPC_HI:`IFD_OPC_LO];
      opOff = 8'h00;
      next_s1Fmt = IFD_FMT_ILLEGAL;
      // Opcode alone selects format, so length is known at capture
      if (opc >= `IFD_REGREG_BASE && opc < `IFD_REGREG_BASE + `IFD_REGREG_CNT) begin
         next_s1Fmt = IFD_FMT_REG_REG;
         opOff = opc - `IFD_REGREG_BASE;
      end else if (opc >= `IFD_RX_BASE && opc < `IFD_RX_BASE + `IFD_RX_CNT) begin
         next_s1Fmt = IFD_FMT_REG_INDEXED;
         opOff = opc - `IFD_RX_BASE;
      end else if (opc >= `IFD_REGSTOR_BASE && opc < `IFD_REGSTOR_BASE + `IFD_REGSTOR_CNT) begin
         next_s1Fmt = IFD_FMT_REG_STORAGE;
         opOff = opc - `IFD_REGSTOR_BASE;
      end else if (opc >= `IFD_SI_BASE && opc < `IFD_SI_BASE + `IFD_SI_CNT) begin
         next_s1Fmt = IFD_FMT_STORAGE_IMM;
         opOff = opc - `IFD_SI_BASE;
      end else if (opc >= `IFD_LONGSS_BASE && opc < `IFD_LONGSS_BASE + `IFD_LONGSS_CNT) begin
         next_s1Fmt = IFD_FMT_LONG_SS;
         opOff = opc - `IFD_LONGSS_BASE;
      end else if (opc >= `IFD_SHORTSS_BASE && opc < `IFD_SHORTSS_BASE + `IFD_SHORTSS_CNT) begin
         next_s1Fmt = IFD_FMT_SHORT_SS;
         opOff = opc - `IFD_SHORTSS_BASE;
      end
      next_s1Op = opOff[4:0];
      next_s1Valid = instrValid;
      next_s1Word = instrWord;
      next_s1Addr = instrAddr;
      next_s1Problem = problemState;
      // Read selects line up with the fields; zero fields are masked later
      next_indexSel = instrWord[`IFD_SECOND_REG_HI:`IFD_SECOND_REG_LO];
      next_baseSel = instrWord[`IFD_B1_HI:`IFD_B1_LO];
      next_secondBaseSel = instrWord[`IFD_BASE_B_HI:`IFD_BASE_B_LO];
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s1Valid <= 1'b0;
         s1Word <= 48'h0000_0000_0000;
         s1Addr <= '0;
         s1Problem <= 1'b0;
         s1Fmt <= IFD_FMT_ILLEGAL;
         s1Op <= 5'h00;
         indexSel <= 4'h0;
         baseSel <= 4'h0;
         secondBaseSel <= 4'h0;
      end else begin
         s1Valid <= next_s1Valid;
         s1Word <= next_s1Word;
         s1Addr <= next_s1Addr;
         s1Problem <= next_s1Problem;
         s1Fmt <= next_s1Fmt;
         s1Op <= next_s1Op;
         indexSel <= next_indexSel;
         baseSel <= next_baseSel;
         secondBaseSel <= next_secondBaseSel;
      end
   end

   // ****************************************
   // Stage 2: fields, addresses, exceptions
   // ****************************************
   logic next_decValid, next_maskValid, next_immValid, next_groupValid;
   logic next_illegalOp, next_privTrap, next_specTrap;
   logic [2:0] next_instrLen, next_operandBytes;
   logic [1:0] next_storageRefs;
   logic [3:0] next_firstReg, next_secondReg, next_mask;
   logic [7:0] next_immValue;
   logic [8:0] next_lenA, next_lenB;
   logic [`IFD_ADDR_W-1:0] next_nextAddr, next_addrA, next_addrB;
   logic [`IFD_WORD_W-1:0] idxTerm, baseTerm, base2Term, sumA, sumB;
   logic [3:0] f1, f2;
   logic privOp;

   always_comb begin
      f1 = s1Word[`IFD_FIRST_REG_HI:`IFD_FIRST_REG_LO];
      f2 = s1Word[`IFD_SECOND_REG_HI:`IFD_SECOND_REG_LO];
      // Register zero means "no register" in address arithmetic
      idxTerm = (f2 == 4'h0) ? '0 : indexData;
      baseTerm = (s1Word[`IFD_B1_HI:`IFD_B1_LO] == 4'h0) ? '0 : baseData;
      base2Term = (s1Word[`IFD_BASE_B_HI:`IFD_BASE_B_LO] == 4'h0) ? '0 : secondBaseData;
      sumA = baseTerm + {20'h0_0000, s1Word[`IFD_D1_HI:`IFD_D1_LO]};
      if (s1Fmt == IFD_FMT_REG_INDEXED) begin
         sumA = sumA + idxTerm;
      end
      sumB = base2Term + {20'h0_0000, s1Word[`IFD_DISP_B_HI:`IFD_DISP_B_LO]};
      next_addrA = sumA[`IFD_ADDR_W-1:0];
      next_addrB = sumB[`IFD_ADDR_W-1:0];
      next_firstReg = f1;
      next_secondReg = f2;
      next_mask = 4'h0;
      next_maskValid = 1'b0;
      next_immValue = 8'h00;
      next_immValid = 1'b0;
      next_groupValid = 1'b0;
      next_lenA = 9'h000;
      next_lenB = 9'h000;
      next_operandBytes = `IFD_BYTES_NONE;
      next_illegalOp = 1'b0;
      privOp = 1'b0;
      unique case (s1Fmt)
         IFD_FMT_REG_REG: begin
            next_instrLen = `IFD_LEN_ONE_HALF;
            next_storageRefs = 2'h0;
            next_operandBytes = `IFD_BYTES_FULL;
            if (s1Op == `IFD_OP_BRANCH_COND_REG) begin
               next_mask = f1;
               next_maskValid = 1'b1;
            end
            if (s1Op == `IFD_OP_SUPERVISOR_CALL || s1Op == `IFD_OP_SET_PROGRAM_MASK) begin
               next_immValue = s1Word[`IFD_FIRST_REG_HI:`IFD_SECOND_REG_LO];
               next_immValid = 1'b1;
            end
         end
         IFD_FMT_REG_INDEXED: begin
            next_instrLen = `IFD_LEN_TWO_HALF;
            next_storageRefs = 2'h1;
            next_operandBytes = `IFD_BYTES_FULL;
            if (s1Op == `IFD_OP_BRANCH_COND) begin
               next_mask = f1;
               next_maskValid = 1'b1;
            end
            if (s1Op == `IFD_OP_ADD_HALF || s1Op == `IFD_OP_COMPARE_HALF || s1Op == `IFD_OP_LOAD_HALF
                  || s1Op == `IFD_OP_STORE_HALF || s1Op == `IFD_OP_SUB_HALF) begin
               next_operandBytes = `IFD_BYTES_HALF;
            end
            if (s1Op == `IFD_OP_INSERT_BYTE || s1Op == `IFD_OP_STORE_BYTE) begin
               next_operandBytes = `IFD_BYTES_CHAR;
            end
            if (s1Op == `IFD_OP_LOAD_EFFECTIVE_ADDR) begin
               next_operandBytes = `IFD_BYTES_NONE;
            end
         end
         IFD_FMT_REG_STORAGE: begin
            next_instrLen = `IFD_LEN_TWO_HALF;
            next_storageRefs = 2'h1;
            privOp = (s1Op == `IFD_OP_LOAD_BOUNDS_REG);
            next_groupValid = (s1Op == `IFD_OP_LOAD_REG_GROUP || s1Op == `IFD_OP_STORE_REG_GROUP);
         end
         IFD_FMT_STORAGE_IMM: begin
            next_instrLen = `IFD_LEN_TWO_HALF;
            next_storageRefs = 2'h1;
            next_immValue = s1Word[`IFD_FIRST_REG_HI:`IFD_SECOND_REG_LO];
            next_immValid = 1'b1;
            privOp = (s1Op >= `IFD_OP_SI_PRIV_FIRST);
         end
         IFD_FMT_LONG_SS: begin
            next_instrLen = `IFD_LEN_THREE_HALF;
            next_storageRefs = 2'h2;
            next_lenA = {1'b0, s1Word[`IFD_FIRST_REG_HI:`IFD_SECOND_REG_LO]} + 9'h001;
            next_lenB = next_lenA;
         end
         IFD_FMT_SHORT_SS: begin
            next_instrLen = `IFD_LEN_THREE_HALF;
            next_storageRefs = 2'h2;
            next_lenA = {5'h00, f1} + 9'h001;
            next_lenB = {5'h00, f2} + 9'h001;
         end
         default: begin
            // Unassigned opcode: one halfword, nothing referenced
            next_instrLen = `IFD_LEN_ONE_HALF;
            next_storageRefs = 2'h0;
            next_illegalOp = 1'b1;
         end
      endcase
      next_nextAddr = s1Addr + {{(`IFD_ADDR_W-3){1'b0}}, next_instrLen};
      next_privTrap = privOp && s1Problem;
      next_specTrap = s1Addr[0];
      // Trapped instructions must not reach storage
      if (next_illegalOp || next_privTrap || next_specTrap) begin
         next_storageRefs = 2'h0;
      end
      next_decValid = s1Valid;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         decValid <= 1'b0;
         format <= IFD_FMT_ILLEGAL;
         opIndex <= 5'h00;
         instrLen <= `IFD_LEN_ONE_HALF;
         nextAddr <= '0;
         firstOperandRegister <= 4'h0;
         secondOperandRegister <= 4'h0;
         conditionTestMask <= 4'h0;
         maskValid <= 1'b0;
         immValue <= 8'h00;
         immValid <= 1'b0;
         groupValid <= 1'b0;
         storageRefs <= 2'h0;
         operandAddrA <= '0;
         operandAddrB <= '0;
         operandLenA <= 9'h000;
         operandLenB <= 9'h000;
         operandBytes <= `IFD_BYTES_NONE;
         illegalOp <= 1'b0;
         privTrap <= 1'b0;
         specTrap <= 1'b0;
      end else begin
         decValid <= next_decValid;
         format <= s1Fmt;
         opIndex <= s1Op;
         instrLen <= next_instrLen;
         nextAddr <= next_nextAddr;
         firstOperandRegister <= next_firstReg;
         secondOperandRegister <= next_secondReg;
         conditionTestMask <= next_mask;
         maskValid <= next_maskValid;
         immValue <= next_immValue;
         immValid <= next_immValid;
         groupValid <= next_groupValid;
         storageRefs <= next_storageRefs;
         operandAddrA <= next_addrA;
         operandAddrB <= next_addrB;
         operandLenA <= next_lenA;
         operandLenB <= next_lenB;
         operandBytes <= next_operandBytes;
         illegalOp <= next_illegalOp;
         privTrap <= next_privTrap;
         specTrap <= next_specTrap;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_len_matches_fmt: assert property (decValid |-> (format == IFD_FMT_REG_REG) == (instrLen == `IFD_LEN_ONE_HALF)
         || format == IFD_FMT_ILLEGAL) else $error("length disagrees with format");
   a_next_addr_step: assert property (s1Valid |=> nextAddr == $past(s1Addr) + {{(`IFD_ADDR_W-3){1'b0}}, instrLen})
         else $error("next address wrong");
   a_regreg_no_storage: assert property (decValid && format == IFD_FMT_REG_REG |-> storageRefs == 2'h0)
         else $error("register format touched storage");
   a_two_half_one_ref: assert property (decValid && instrLen == `IFD_LEN_TWO_HALF && !illegalOp && !privTrap
         && !specTrap |-> storageRefs == 2'h1) else $error("four-byte op ref count");
   a_three_half_two: assert property (decValid && instrLen == `IFD_LEN_THREE_HALF && !specTrap
         |-> storageRefs == 2'h2) else $error("six-byte op ref count");
   a_long_ss_limit: assert property (decValid && format == IFD_FMT_LONG_SS |-> operandLenA <= `IFD_LONG_SS_MAX
         && operandLenA != 9'h000) else $error("long operand out of range");
   a_short_ss_limit: assert property (decValid && format == IFD_FMT_SHORT_SS |-> operandLenA <= `IFD_SHORT_SS_MAX
         && operandLenB <= `IFD_SHORT_SS_MAX) else $error("short operand out of range");
   a_odd_addr_spec: assert property (instrValid && instrAddr[0] |-> ##2 specTrap && storageRefs == 2'h0)
         else $error("odd address not trapped");
   a_priv_problem: assert property (instrValid && problemState && instrWord[`IFD_OPC_HI:`IFD_OPC_LO]
         == `IFD_REGSTOR_BASE |-> ##2 privTrap) else $error("privileged op not trapped");
   a_illegal_opcode: assert property (instrValid && instrWord[`IFD_OPC_HI:`IFD_OPC_LO] == 8'h3F |-> ##2 illegalOp
         && format == IFD_FMT_ILLEGAL) else $error("unassigned opcode accepted");
   a_zero_base: assert property (s1Valid && s1Fmt == IFD_FMT_REG_STORAGE && s1Word[`IFD_B1_HI:`IFD_B1_LO] == 4'h0
         |=> operandAddrA == {12'h000, $past(s1Word[`IFD_D1_HI:`IFD_D1_LO])}) else $error("zero base used");

   c_regreg_decode: cover property (decValid && format == IFD_FMT_REG_REG && maskValid);
   c_rx_indexed: cover property (decValid && format == IFD_FMT_REG_INDEXED && storageRefs == 2'h1);
   c_priv_trap: cover property (decValid && privTrap);
   c_long_ss_max: cover property (decValid && operandLenA == `IFD_LONG_SS_MAX);
endmodule : ifd_decoder

/* verilog/ifd_defines.svh */
`ifndef IFD_DEFINES_SVH
`define IFD_DEFINES_SVH

// ****************************************
// Widths
// ****************************************
`define IFD_ADDR_W 24
`define IFD_WORD_W 32

// ****************************************
// Field positions, first halfword in [47:32]
// ****************************************
`define IFD_OPC_HI 47
`define IFD_OPC_LO 40
`define IFD_FIRST_REG_HI 39
`define IFD_FIRST_REG_LO 36
`define IFD_SECOND_REG_HI 35
`define IFD_SECOND_REG_LO 32
`define IFD_B1_HI 31
`define IFD_B1_LO 28
`define IFD_D1_HI 27
`define IFD_D1_LO 16
`define IFD_BASE_B_HI 15
`define IFD_BASE_B_LO 12
`define IFD_DISP_B_HI 11
`define IFD_DISP_B_LO 0

// ****************************************
// Opcode map: base and count of each format
// ****************************************
`define IFD_REGREG_BASE 8'h00
`define IFD_REGREG_CNT 8'h0E
`define IFD_RX_BASE 8'h40
`define IFD_RX_CNT 8'h14
`define IFD_REGSTOR_BASE 8'h80
`define IFD_REGSTOR_CNT 8'h05
`define IFD_SI_BASE 8'h90
`define IFD_SI_CNT 8'h0B
`define IFD_LONGSS_BASE 8'hD0
`define IFD_LONGSS_CNT 8'h09
`define IFD_SHORTSS_BASE 8'hF0
`define IFD_SHORTSS_CNT 8'h09

// ****************************************
// Operation indices within a format
// ****************************************
`define IFD_OP_BRANCH_COND_REG 5'h03
`define IFD_OP_SET_PROGRAM_MASK 5'h0B
`define IFD_OP_SUPERVISOR_CALL 5'h0D
`define IFD_OP_ADD_HALF 5'h01
`define IFD_OP_BRANCH_COND 5'h04
`define IFD_OP_COMPARE_HALF 5'h07
`define IFD_OP_INSERT_BYTE 5'h0A
`define IFD_OP_LOAD_EFFECTIVE_ADDR 5'h0C
`define IFD_OP_LOAD_HALF 5'h0D
`define IFD_OP_STORE_BYTE 5'h10
`define IFD_OP_STORE_HALF 5'h11
`define IFD_OP_SUB_HALF 5'h13
`define IFD_OP_LOAD_BOUNDS_REG 5'h00
`define IFD_OP_LOAD_REG_GROUP 5'h01
`define IFD_OP_STORE_REG_GROUP 5'h04
`define IFD_OP_SI_PRIV_FIRST 5'h07

// ****************************************
// Lengths and limits
// ****************************************
`define IFD_LEN_ONE_HALF 3'h2
`define IFD_LEN_TWO_HALF 3'h4
`define IFD_LEN_THREE_HALF 3'h6
`define IFD_BYTES_FULL 3'h4
`define IFD_BYTES_HALF 3'h2
`define IFD_BYTES_CHAR 3'h1
`define IFD_BYTES_NONE 3'h0
`define IFD_LONG_SS_MAX 9'h100
`define IFD_SHORT_SS_MAX 9'h010

`endif

/* verilog/ifd_pkg.sv */
package ifd_pkg;
   typedef enum logic [2:0] {
      IFD_FMT_REG_REG = 3'b000,
      IFD_FMT_REG_INDEXED = 3'b001,
      IFD_FMT_REG_STORAGE = 3'b010,
      IFD_FMT_STORAGE_IMM = 3'b011,
      IFD_FMT_LONG_SS = 3'b100,
      IFD_FMT_SHORT_SS = 3'b101,
      IFD_FMT_ILLEGAL = 3'b111
   } ifd_format_t;
endpackage : ifd_pkg

/* sim/ifd_regfile_model.sv */
module ifd_regfile_model (
   // Register selects from the decoder
   input wire logic [3:0] indexSel,
   input wire logic [3:0] baseSel,
   input wire logic [3:0] secondBaseSel,
   // Register contents back, same cycle
   output logic [31:0] indexData,
   output logic [31:0] baseData,
   output logic [31:0] secondBaseData
);
   timeunit 1ns;
   timeprecision 1ps;
   // Loaded by the bench; register zero is nonzero on purpose
   logic [31:0] regs [16];
   assign indexData = regs[indexSel];
   assign baseData = regs[baseSel];
   assign secondBaseData = regs[secondBaseSel];
endmodule : ifd_regfile_model

/* sim/tb_top.sv */
module tb_top;
   import ifd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [2:0] fmt; logic [4:0] opIdx; logic [2:0] len; logic [23:0] nxt; logic [3:0] regA; logic [3:0] regB;
      logic [3:0] tmask; logic mval; logic [7:0] imm; logic ival; logic gval; logic [1:0] refs;
      logic [23:0] adrA; logic [23:0] adrB; logic [8:0] lenA; logic [8:0] lenB; logic [2:0] nbytes;
      logic ill; logic priv; logic spec;
   } ifd_tb_exp_t;
   logic clk_sys = 1'b0, rst = 1'b1, instrValid = 1'b0, problemState = 1'b0;
   logic [47:0] instrWord = 48'h0000_0000_0000;
   logic [23:0] instrAddr = 24'h00_0000;
   logic [3:0] indexSel, baseSel, secondBaseSel, firstOperandRegister, secondOperandRegister, conditionTestMask;
   logic [31:0] indexData, baseData, secondBaseData;
   logic decValid, maskValid, immValid, groupValid, illegalOp, privTrap, specTrap;
   ifd_format_t format;
   logic [4:0] opIndex;
   logic [2:0] instrLen, operandBytes;
   logic [23:0] nextAddr, operandAddrA, operandAddrB;
   logic [7:0] immValue;
   logic [1:0] storageRefs;
   logic [8:0] operandLenA, operandLenB;
   ifd_tb_exp_t expQ [$], mskQ [$];
   int miscompares = 0, num_checks = 0;

   always #12.5 clk_sys = ~clk_sys;

   ifd_decoder uut (.clk_sys(clk_sys), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
      .instrAddr(instrAddr), .problemState(problemState), .indexSel(indexSel), .baseSel(baseSel),
      .secondBaseSel(secondBaseSel), .indexData(indexData), .baseData(baseData),
      .secondBaseData(secondBaseData), .decValid(decValid), .format(format), .opIndex(opIndex),
      .instrLen(instrLen), .nextAddr(nextAddr), .firstOperandRegister(firstOperandRegister),
      .secondOperandRegister(secondOperandRegister), .conditionTestMask(conditionTestMask),
      .maskValid(maskValid), .immValue(immValue), .immValid(immValid), .groupValid(groupValid),
      .storageRefs(storageRefs), .operandAddrA(operandAddrA), .operandAddrB(operandAddrB),
      .operandLenA(operandLenA), .operandLenB(operandLenB), .operandBytes(operandBytes),
      .illegalOp(illegalOp), .privTrap(privTrap), .specTrap(specTrap));

   ifd_regfile_model rfm (.indexSel(indexSel), .baseSel(baseSel), .secondBaseSel(secondBaseSel),
      .indexData(indexData), .baseData(baseData), .secondBaseData(secondBaseData));

   // ****************************************
   // Reference model
   // ****************************************
   function automatic logic [31:0] regv(input logic [3:0] s);
      return (s == 4'h0) ? 32'h0000_0000 : rfm.regs[s];
   endfunction : regv

   function automatic ifd_tb_exp_t predict(input logic [47:0] w, input logic [23:0] a, input logic p,
                                          output ifd_tb_exp_t m);
      logic [7:0] opc;
      logic [2:0] f;
      logic [4:0] ix;
      logic [31:0] sum;
      ifd_tb_exp_t e;
      opc = w[47:40];
      e = '0;
      m = '1;
      f = 3'b111;
      ix = opc[4:0];
      if (opc <= 8'h0D) f = IFD_FMT_REG_REG;
      else if (opc >= 8'h40 && opc <= 8'h53) begin f = IFD_FMT_REG_INDEXED; ix = 5'(opc - 8'h40); end
      else if (opc >= 8'h80 && opc <= 8'h84) begin f = IFD_FMT_REG_STORAGE; ix = 5'(opc - 8'h80); end
      else if (opc >= 8'h90 && opc <= 8'h9A) begin f = IFD_FMT_STORAGE_IMM; ix = 5'(opc - 8'h90); end
      else if (opc >= 8'hD0 && opc <= 8'hD8) begin f = IFD_FMT_LONG_SS; ix = 5'(opc - 8'hD0); end
      else if (opc >= 8'hF0 && opc <= 8'hF8) begin f = IFD_FMT_SHORT_SS; ix = 5'(opc - 8'hF0); end
      e.fmt = f;
      e.opIdx = ix;
      e.len = (f == 3'b000) ? 3'h2 : (f >= 3'b100) ? 3'h6 : 3'h4;
      e.nxt = a + 24'(e.len);
      e.regA = w[39:36];
      e.regB = w[35:32];
      e.mval = (f == 3'b000 && ix == 5'h03) || (f == 3'b001 && ix == 5'h04);
      e.tmask = e.mval ? w[39:36] : 4'h0;
      e.ival = (f == 3'b000 && (ix == 5'h0B || ix == 5'h0D)) || f == 3'b011;
      e.imm = e.ival ? w[39:32] : 8'h00;
      e.gval = f == 3'b010 && (ix == 5'h01 || ix == 5'h04);
      e.spec = a[0];
      e.priv = p && ((f == 3'b010 && ix == 5'h00) || (f == 3'b011 && ix >= 5'h07 && ix <= 5'h0A));
      e.ill = (f == 3'b111);
      e.refs = (e.spec || e.priv || e.ill || f == 3'b000) ? 2'h0 : (f >= 3'b100) ? 2'h2 : 2'h1;
      sum = regv(w[31:28]) + 32'(w[27:16]) + ((f == 3'b001) ? regv(w[35:32]) : 32'h0000_0000);
      e.adrA = sum[23:0];
      sum = regv(w[15:12]) + 32'(w[11:0]);
      e.adrB = sum[23:0];
      if (f == 3'b100) begin e.lenA = 9'(w[39:32]) + 9'h001; e.lenB = e.lenA; end
      if (f == 3'b101) begin e.lenA = 9'(w[39:36]) + 9'h001; e.lenB = 9'(w[35:32]) + 9'h001; end
      if (f == 3'b000) e.nbytes = 3'h4;
      if (f == 3'b001) begin
         case (ix)
            5'h01, 5'h07, 5'h0D, 5'h11, 5'h13: e.nbytes = 3'h2;
            5'h0A, 5'h10: e.nbytes = 3'h1;
            5'h0C: e.nbytes = 3'h0;
            default: e.nbytes = 3'h4;
         endcase
      end
      if (f == 3'b000) m.adrA = '0;
      if (f < 3'b100) m.adrB = '0;
      if (e.ill) begin m = '0; m.fmt = '1; m.refs = '1; m.ill = '1; m.spec = '1; end
      return e;
   endfunction : predict

   // ****************************************
   // Driver tasks
   // ****************************************
   task automatic issue(input logic [47:0] w, input logic [23:0] a, input logic p);
      ifd_tb_exp_t e, m;
      @(posedge clk_sys);
      instrValid <= 1'b1;
      instrWord <= w;
      instrAddr <= a;
      problemState <= p;
      e = predict(w, a, p, m);
      expQ.push_back(e);
      mskQ.push_back(m);
   endtask : issue

   task automatic drain(input string name);
      int n;
      n = 0;
      while (expQ.size() != 0 && n < 10) begin
         @(posedge clk_sys);
         instrValid <= 1'b0;
         n++;
      end
      if (expQ.size() != 0) begin
         miscompares++;
         $display("BAD %0t pending %h exp %h", $time, expQ.size(), 0);
      end
      $display("%s done, checks %0d, mismatches %0d", name, num_checks, miscompares);
   endtask : drain

   task automatic chk_reset();
      @(negedge clk_sys);
      num_checks++;
      if ({format, instrLen, decValid, storageRefs, illegalOp} !== {3'b111, 3'h2, 1'b0, 2'h0, 1'b0}) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, {format, instrLen, decValid}, {3'b111, 3'h2, 1'b0});
      end
   endtask : chk_reset

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test

   // ****************************************
   // Monitor
   // ****************************************
   always @(negedge clk_sys) begin
      ifd_tb_exp_t e, m, got;
      if (!rst && decValid === 1'b1) begin
         if (expQ.size() == 0) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, opIndex, 0);
         end else begin
            e = expQ.pop_front();
            m = mskQ.pop_front();
            got = {format, opIndex, instrLen, nextAddr, firstOperandRegister, secondOperandRegister,
               conditionTestMask, maskValid, immValue, immValid, groupValid, storageRefs, operandAddrA,
               operandAddrB, operandLenA, operandLenB, operandBytes, illegalOp, privTrap, specTrap};
            num_checks++;
            if ((got & m) !== (e & m)) begin
               miscompares++;
               $display("BAD %0t got %h exp %h", $time, got & m, e & m);
            end
         end
      end
   end

   initial begin
      #(25ns * 5000);
      miscompares++;
      end_of_test();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      void'($urandom(83));
      for (int k = 0; k < 16; k++) rfm.regs[k] = $urandom();
      rfm.regs[0] = 32'h0F0F_0F0F;
      repeat (12) @(posedge clk_sys);
      chk_reset();
      @(posedge clk_sys);
      rst <= 1'b0;
      for (int i = 0; i < 256; i++) begin
         issue({8'(i), 8'($urandom()), 32'($urandom())}, 24'($urandom()) & 24'hFF_FFFE, 1'b0);
      end
      drain("opcode sweep");
      for (int i = 0; i < 300; i++) begin
         issue({8'($urandom()), 8'($urandom()), 32'($urandom())}, 24'($urandom()), 1'($urandom()));
      end
      drain("random traps");
      for (int j = 0; j < 4; j++) begin
         issue({8'h40 + 8'(j), 8'h50, 32'h0FFF_0800}, 24'h00_1000, 1'b0);
         issue({8'hD0 + 8'(j), 8'hFF, 32'h0000_0123}, 24'h00_1002, 1'b0);
      end
      issue({8'h84, 8'h12, 32'h0ABC_0000}, 24'h00_1004, 1'b0);
      issue({8'h80, 8'h12, 32'h3004_0000}, 24'h00_1008, 1'b1);
      drain("zero base and index");
      issue({8'h82, 8'h12, 32'h3004_0000}, 24'h00_2000, 1'b0);
      issue({8'h00, 8'h12, 32'h0000_0000}, 24'h00_2004, 1'b0);
      @(posedge clk_sys);
      rst <= 1'b1;
      instrValid <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk_reset();
      expQ.delete();
      mskQ.delete();
      @(posedge clk_sys);
      rst <= 1'b0;
      issue({8'hF0, 8'hFF, 32'h1001_2002}, 24'h00_3000, 1'b1);
      drain("reset in flight");
      end_of_test();
   end
endmodule : tb_top
